// *** include/sac_pkg.sv ***
// Package: constants and types for the SAR converter control block
package sac_pkg;
  localparam int RES_W = 10;
  localparam int CH_W = 5;
  localparam logic [4:0] CH_OFF = 5'h1F;
  localparam logic [9:0] RESULT_RST = 10'h000;
  // Cycle budgets in converter clocks; the sync wait in bus clocks
  localparam logic [5:0] SHORT_8_CLKS = 6'h12;
  localparam logic [5:0] LONG_8_CLKS = 6'h26;
  localparam logic [5:0] SHORT_10_CLKS = 6'h15;
  localparam logic [5:0] LONG_10_CLKS = 6'h29;
  localparam logic [5:0] NEXT_DISCOUNT = 6'h02;
  localparam logic [1:0] SYNC_BUS_CLKS = 2'h3;
  // Async clock start-up allowance
  localparam int STARTUP_NS = 5000;
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [6:0] STARTUP_CLKS = 7'((STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SAR_STEPS = 10;
  typedef enum logic [2:0] {
    SAC_IDLE = 3'b000,
    SAC_SYNC = 3'b001,
    SAC_START = 3'b010,
    SAC_CONV = 3'b011,
    SAC_XFER = 3'b100
  } sac_state_type;
  typedef enum logic [1:0] {
    SAC_SRC_ALT = 2'b00,
    SAC_SRC_BUS = 2'b01,
    SAC_SRC_ASYNC = 2'b10
  } sac_src_type;
endpackage

// *** rtl/sac_clkdiv.sv ***
// Converter clock divider producing one-cycle enable pulses
`timescale 1ns/1ps
`default_nettype none
module sac_clkdiv
  import sac_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Control
  input wire logic run_i,
  input wire logic src_tick_i,
  input wire logic [1:0] clock_divide_sel_i,
  // Output
  output logic tick_o
);
  logic [2:0] cnt;
  wire [2:0] div_max = 3'((4'h1 << clock_divide_sel_i) - 4'h1);
  wire wrap = (cnt >= div_max);
  // Counter held at zero while stopped so a conversion started from idle starts aligned
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cnt <= 3'h0;
    else if (!run_i)
      cnt <= 3'h0;
    else if (src_tick_i)
      cnt <= wrap ? 3'h0 : 3'(cnt + 3'h1);
  end
  assign tick_o = run_i && src_tick_i && wrap;
endmodule
`default_nettype wire

// *** rtl/sac_ctrl.sv ***
// SAR converter conversion control: clocking, start, abort, result transfer
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl
  import sac_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Status and control register write
  input wire logic status_control_wr_i,
  input wire logic [4:0] channel_select_i,
  input wire logic continuous_conv_en_i,
  input wire logic completion_irq_en_i,
  // Clock configuration register write
  input wire logic clock_config_wr_i,
  input wire logic async_clock_sel_i,
  input wire logic input_clock_sel_i,
  input wire logic [1:0] clock_divide_sel_i,
  input wire logic low_power_cfg_i,
  input wire logic long_sample_sel_i,
  input wire logic mode_10bit_i,
  // Result register reads
  input wire logic result_high_rd_i,
  input wire logic result_low_rd_i,
  // System
  input wire logic stop_mode_i,
  input wire logic bus_clock_times_four_tick_i,
  input wire logic async_osc_tick_i,
  // Analog side: comparator answer to the trial value
  input wire logic comparator_i,
  output logic [4:0] selected_analog_input_o,
  output logic [10:0] trial_value_o,
  output logic sample_o,
  output logic analog_on_o,
  output logic async_osc_en_o,
  output logic async_osc_half_o,
  // Status
  output logic [9:0] result_o,
  output logic [1:0] result_high_reg_o,
  output logic [7:0] result_low_reg_o,
  output logic conversion_done_flag_o,
  output logic irq_o,
  output logic busy_o,
  output logic [1:0] clock_src_o
);
  // ------------------------------------------------------------
  // Configuration latches
  // ------------------------------------------------------------
  logic [4:0] chan;
  logic cont_en, irq_en, async_sel, iclk_sel, lp_cfg, long_smp, mode10;
  logic [1:0] div_sel;
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      chan <= CH_OFF;
      cont_en <= 1'b0;
      irq_en <= 1'b0;
    end
    else if (status_control_wr_i)
    begin
      chan <= channel_select_i;
      cont_en <= continuous_conv_en_i;
      irq_en <= completion_irq_en_i;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      async_sel <= 1'b0;
      iclk_sel <= 1'b0;
      div_sel <= 2'h0;
      lp_cfg <= 1'b0;
      long_smp <= 1'b0;
      mode10 <= 1'b0;
    end
    else if (clock_config_wr_i)
    begin
      async_sel <= async_clock_sel_i;
      iclk_sel <= input_clock_sel_i;
      div_sel <= clock_divide_sel_i;
      lp_cfg <= low_power_cfg_i;
      long_smp <= long_sample_sel_i;
      mode10 <= mode_10bit_i;
    end
  end
  // ------------------------------------------------------------
  // Clock select and divide
  // ------------------------------------------------------------
  sac_state_type state, next_state;
  wire running = (state != SAC_IDLE);
  wire [1:0] src = async_sel ? SAC_SRC_ASYNC : (iclk_sel ? SAC_SRC_BUS : SAC_SRC_ALT);
  // Alternate source is bus times four, seen here as a tick each bus cycle
  wire src_tick = (src == SAC_SRC_ASYNC) ? async_osc_tick_i :
                  (src == SAC_SRC_BUS) ? 1'b1 : bus_clock_times_four_tick_i;
  wire conv_tick;
  sac_clkdiv u_div (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .run_i(running),
    .src_tick_i(src_tick),
    .clock_divide_sel_i(div_sel),
    .tick_o(conv_tick)
  );
  assign async_osc_en_o = running && async_sel;
  assign async_osc_half_o = lp_cfg;
  assign clock_src_o = src;
  // ------------------------------------------------------------
  // Start and abort decode
  // ------------------------------------------------------------
  // Only software starts exist; no hardware trigger input
  wire sw_start = status_control_wr_i && (channel_select_i != CH_OFF);
  // With the async clock selected, stop entry does not abort and the conversion finishes
  wire stop_abort = stop_mode_i && !async_sel;
  wire abort = status_control_wr_i || clock_config_wr_i || stop_abort;
  // Budget in converter clocks for a single or first continuous conversion
  function automatic logic [5:0] first_budget(input logic ten_bit, input logic long_sample);
    logic [5:0] n;
    if (ten_bit)
      n = long_sample ? LONG_10_CLKS : SHORT_10_CLKS;
    else
      n = long_sample ? LONG_8_CLKS : SHORT_8_CLKS;
    return n;
  endfunction
  // Later continuous conversions skip the start-up and lose two clocks
  wire [5:0] budget = first_budget(mode10, long_smp);
  logic first_conv;
  wire [5:0] budget_eff = first_conv ? budget : 6'(budget - NEXT_DISCOUNT);
  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  logic [6:0] wait_cnt;
  logic [5:0] clk_cnt;
  logic [10:0] sar;
  logic [3:0] bit_idx;
  logic high_read;
  // A blocked result is dropped and the conversion reruns, which costs power if software misreads
  wire blocked = mode10 && high_read;
  // The transfer cycle stands in for the last converter clock, so the budget is never exceeded
  wire sample_done = (clk_cnt + 6'(SAR_STEPS) + 6'h2) >= budget_eff;
  wire conv_end = conv_tick && (clk_cnt + 6'h2 >= budget_eff);
  always_comb
  begin
    next_state = state;
    case (state)
      SAC_IDLE: next_state = SAC_IDLE;
      SAC_SYNC: if (wait_cnt == 7'h0) next_state = async_sel ? SAC_START : SAC_CONV;
      SAC_START: if (wait_cnt == 7'h0) next_state = SAC_CONV;
      SAC_CONV: if (conv_end) next_state = SAC_XFER;
      // Continuous, or a blocked transfer, restarts
      SAC_XFER: next_state = (cont_en || blocked) ? SAC_CONV : SAC_IDLE;
      default: next_state = SAC_IDLE;
    endcase
  end
  // Abort drops straight to idle, or to sync when it is a start write; the analog side powers off at once
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state <= SAC_IDLE;
    else if (abort)
      state <= sw_start ? SAC_SYNC : SAC_IDLE;
    else
      state <= next_state;
  end
  // Sync wait first, then the oscillator start-up allowance when the async clock is used
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      wait_cnt <= 7'h0;
    else if (abort)
      wait_cnt <= 7'(SYNC_BUS_CLKS - 2'h1);
    else if (state == SAC_SYNC && wait_cnt == 7'h0)
      wait_cnt <= 7'(STARTUP_CLKS - 7'h1);
    else if (wait_cnt != 7'h0)
      wait_cnt <= 7'(wait_cnt - 7'h1);
  end
  // Any abort makes the next conversion a first one again, with the full budget
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      first_conv <= 1'b1;
    else if (abort)
      first_conv <= 1'b1;
    else if (state == SAC_XFER)
      first_conv <= 1'b0;
  end
  // Successive approximation with one extra bit so the result can round
  wire [3:0] top_bit = mode10 ? 4'hA : 4'h8;
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      clk_cnt <= 6'h0;
      sar <= 11'h000;
      bit_idx <= 4'h0;
    end
    else if (state != SAC_CONV)
    begin
      clk_cnt <= 6'h0;
      sar <= 11'h000;
      bit_idx <= top_bit;
    end
    else if (conv_tick)
    begin
      clk_cnt <= 6'(clk_cnt + 6'h1);
      if (sample_done && bit_idx != 4'hF)
      begin
        if (!comparator_i)
          sar[bit_idx] <= 1'b0;
        if (bit_idx != 4'h0)
          sar[bit_idx - 4'h1] <= 1'b1;
        bit_idx <= 4'(bit_idx - 4'h1);
      end
      else if (sample_done)
        bit_idx <= 4'hF;
      else
        sar <= 11'(11'h1 << top_bit);
    end
  end
  // ------------------------------------------------------------
  // Analog side
  // ------------------------------------------------------------
  // 8-bit trials sit at the top of the scale so both modes span the full input range
  assign trial_value_o = mode10 ? sar : {sar[8:0], 2'h0};
  assign sample_o = (state == SAC_CONV) && !sample_done;
  // Power drops in the abort cycle itself rather than one clock later
  assign analog_on_o = running && !abort;
  assign selected_analog_input_o = chan;
  assign busy_o = running;
  // ------------------------------------------------------------
  // Rounding and result transfer
  // ------------------------------------------------------------
  // Round half up, saturating so full scale does not wrap
  wire [10:0] rnd10 = (sar[10:1] == 10'h3FF) ? {1'b0, sar[10:1]} : 11'(sar[10:1] + {9'h0, sar[0]});
  wire [8:0] rnd8 = (sar[8:1] == 8'hFF) ? {1'b0, sar[8:1]} : 9'(sar[8:1] + {7'h0, sar[0]});
  wire [9:0] rounded = mode10 ? rnd10[9:0] : {2'h0, rnd8[7:0]};
  wire xfer = (state == SAC_XFER) && !abort && !blocked;
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      result_o <= RESULT_RST;
    else if (xfer)
      result_o <= rounded;
  end
  assign result_high_reg_o = result_o[9:8];
  assign result_low_reg_o = result_o[7:0];
  // Torn-read guard: high read arms it, low read releases it
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      high_read <= 1'b0;
    else if (result_low_rd_i)
      high_read <= 1'b0;
    else if (result_high_rd_i)
      high_read <= 1'b1;
  end
  // Set wins over a same-cycle clear so no completion is lost
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      conversion_done_flag_o <= 1'b0;
    else if (xfer)
      conversion_done_flag_o <= 1'b1;
    else if (status_control_wr_i || result_low_rd_i)
      conversion_done_flag_o <= 1'b0;
  end
  // Enable sampled at flag set time
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      irq_o <= 1'b0;
    else if (xfer)
      irq_o <= irq_en;
    else if (status_control_wr_i || result_low_rd_i)
      irq_o <= 1'b0;
  end
endmodule
`default_nettype wire

// *** sim/sac_ctrl_sva.sv ***
// Assertions on the conversion control ports
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_sva
  import sac_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic status_control_wr_i,
  input wire logic [4:0] channel_select_i,
  input wire logic clock_config_wr_i,
  input wire logic async_clock_sel_i,
  input wire logic input_clock_sel_i,
  input wire logic low_power_cfg_i,
  input wire logic stop_mode_i,
  input wire logic result_low_rd_i,
  input wire logic [4:0] selected_analog_input_o,
  input wire logic async_osc_en_o,
  input wire logic async_osc_half_o,
  input wire logic [9:0] result_o,
  input wire logic conversion_done_flag_o,
  input wire logic irq_o,
  input wire logic busy_o,
  input wire logic analog_on_o,
  input wire logic [1:0] clock_src_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_start;
    status_control_wr_i && channel_select_i != CH_OFF && !stop_mode_i && !clock_config_wr_i;
  endsequence
  sequence s_cfg(a, b);
    clock_config_wr_i && async_clock_sel_i == a && input_clock_sel_i == b;
  endsequence
  a_src_async: assert property (clock_config_wr_i && async_clock_sel_i |=> clock_src_o == 2'h2)
    else $error("async source not selected");
  a_src_bus: assert property (s_cfg(1'b0, 1'b1) |=> clock_src_o == 2'h1)
    else $error("bus source not selected");
  a_src_alt: assert property (s_cfg(1'b0, 1'b0) |=> clock_src_o == 2'h0)
    else $error("alternate source not selected");
  a_start_busy: assert property (s_start |=> busy_o && selected_analog_input_o == $past(channel_select_i))
    else $error("write did not start a conversion");
  a_off_idle: assert property (status_control_wr_i && channel_select_i == CH_OFF |=> !busy_o)
    else $error("powered-down channel started");
  a_cfg_abort: assert property (busy_o && clock_config_wr_i && !status_control_wr_i |=> !busy_o)
    else $error("config write did not abort");
  a_stop_abort: assert property (busy_o && stop_mode_i && clock_src_o != 2'h2 && !status_control_wr_i |=> !busy_o)
    else $error("stop entry did not abort");
  a_abort_keeps: assert property (busy_o && clock_config_wr_i |=> $stable(result_o))
    else $error("abort altered result");
  a_irq_flag: assert property (irq_o |-> conversion_done_flag_o)
    else $error("irq without done flag");
  a_osc_gated: assert property (async_osc_en_o |-> busy_o && clock_src_o == 2'h2)
    else $error("async oscillator on while idle");
  a_osc_half: assert property (clock_config_wr_i |=> async_osc_half_o == $past(low_power_cfg_i))
    else $error("oscillator range wrong");
  a_flag_clear: assert property (result_low_rd_i && !busy_o |=> !conversion_done_flag_o)
    else $error("low read kept flag");
  a_result_flag: assert property ($changed(result_o) |-> conversion_done_flag_o)
    else $error("result moved without done flag");
  a_abort_power: assert property (clock_config_wr_i |-> !analog_on_o)
    else $error("analog side powered during abort");
endmodule
bind sac_ctrl sac_ctrl_sva sac_ctrl_sva_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
  .status_control_wr_i(status_control_wr_i), .channel_select_i(channel_select_i),
  .clock_config_wr_i(clock_config_wr_i), .async_clock_sel_i(async_clock_sel_i),
  .input_clock_sel_i(input_clock_sel_i), .low_power_cfg_i(low_power_cfg_i),
  .stop_mode_i(stop_mode_i), .result_low_rd_i(result_low_rd_i),
  .selected_analog_input_o(selected_analog_input_o), .async_osc_en_o(async_osc_en_o),
  .async_osc_half_o(async_osc_half_o), .result_o(result_o), .irq_o(irq_o), .busy_o(busy_o),
  .analog_on_o(analog_on_o),
  .conversion_done_flag_o(conversion_done_flag_o), .clock_src_o(clock_src_o));
`default_nettype wire

// *** sim/sac_mux_model.sv ***
// Analog input multiplexer model answering the converter's trial values
`timescale 1ns/1ps
`default_nettype none
module sac_mux_model
  import sac_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Converter side
  input wire logic [4:0] selected_analog_input_i,
  input wire logic [10:0] trial_value_i,
  input wire logic [10:0] level_i [32],
  output logic comparator_o
);
  logic idle_pattern = 1'b0;
  // No input is routed when powered down, so the output must not look settled
  always @(posedge sys_clk_i) idle_pattern <= ~idle_pattern;
  assign comparator_o = (selected_analog_input_i == CH_OFF) ? idle_pattern :
    (level_i[selected_analog_input_i] >= trial_value_i);
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking testbench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sac_pkg::*;
  logic clk = 0, rstn = 0, scw = 0, cont = 0, ien = 0, ccw = 0, asel = 0, isel = 0, lp = 0;
  logic ls = 0, m10 = 0, hrd = 0, lrd = 0, stp = 0, atk = 0, prev = 0, cmp, done, irq, busy, osc;
  logic [4:0] ch = 0, sel;
  logic [1:0] dv = 0, rh, src;
  logic [10:0] trial;
  logic [7:0] rl;
  logic [10:0] lvl [32];
  logic [10:0] expq [$];
  logic [6:0] cf [4] = '{7'h21, 7'h3A, 7'h0B, 7'h54};
  int err_count = 0, n_checks = 0;
  sac_ctrl sac_ctrl_inst (.sys_clk_i(clk), .rstn_i(rstn), .status_control_wr_i(scw),
    .channel_select_i(ch), .continuous_conv_en_i(cont), .completion_irq_en_i(ien),
    .clock_config_wr_i(ccw), .async_clock_sel_i(asel), .input_clock_sel_i(isel),
    .clock_divide_sel_i(dv), .low_power_cfg_i(lp), .long_sample_sel_i(ls), .mode_10bit_i(m10),
    .result_high_rd_i(hrd), .result_low_rd_i(lrd), .stop_mode_i(stp),
    .bus_clock_times_four_tick_i(1'b1), .async_osc_tick_i(atk), .comparator_i(cmp),
    .selected_analog_input_o(sel), .trial_value_o(trial), .sample_o(), .analog_on_o(),
    .async_osc_en_o(osc), .async_osc_half_o(), .result_o(), .result_high_reg_o(rh),
    .result_low_reg_o(rl), .conversion_done_flag_o(done), .irq_o(irq), .busy_o(busy),
    .clock_src_o(src));
  sac_mux_model sac_mux_model_inst (.sys_clk_i(clk), .selected_analog_input_i(sel),
    .trial_value_i(trial), .level_i(lvl), .comparator_o(cmp));
  initial forever #50 clk = ~clk;
  // Oscillator edges arrive irregularly, and only while it is enabled
  always @(posedge clk) atk <= #1 osc && 1'($urandom);
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(logic [15:0] got, logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [9:0] rnd(logic [10:0] l);
    if (m10)
      return (l > 11'h7FE) ? 10'h3FF : 10'((int'(l) + 1) >> 1);
    return (l > 11'h7FB) ? 10'h0FF : 10'((int'(l) + 4) >> 3);
  endfunction
  // Worst-case cycles of a first conversion; async edges are random, so only a loose cap
  function automatic int budget_cycles();
    int n;
    n = m10 ? (ls ? LONG_10_CLKS : SHORT_10_CLKS) : (ls ? LONG_8_CLKS : SHORT_8_CLKS);
    return asel ? 3000 : n * (1 << dv) + int'(SYNC_BUS_CLKS);
  endfunction
  task automatic cfg(logic [6:0] v);
    {asel, isel, dv, lp, ls, m10} = v;
    ccw = 1;
    tick();
    ccw = 0;
  endtask
  task automatic wait_rd(int lim = 3000);
    repeat (lim) if (!done) tick();
    check(done, 1);
    lrd = 1;
    tick();
    lrd = 0;
  endtask
  task automatic start(logic [4:0] c, logic ie, logic co);
    {ch, ien, cont} = {c, ie, co};
    scw = 1;
    tick();
    scw = 0;
  endtask
  task automatic conv(logic [4:0] c, logic ie, logic blk = 0);
    lvl[c] = 11'($urandom);
    expq.push_back({ie, rnd(lvl[c])});
    start(c, ie, 0);
    if (blk)
    begin
      tick(600);
      check(done, 0);
      lrd = 1;
      tick();
      lrd = 0;
    end
    wait_rd(blk ? 3000 : budget_cycles());
  endtask
  always @(negedge clk)
  begin
    prev <= done;
    if (done && !prev)
      check({irq, rh, rl}, expq.size() ? expq.pop_front() : 11'h7FF);
  end
  initial
  begin
    #(20000 * 100);
    err_count++;
    summarize();
  end
  initial
  begin
    void'($urandom(32'h9AAC891A));
    foreach (lvl[i]) lvl[i] = 11'h0;
    tick(8);
    rstn = 1;
    tick();
    check({done, sel, rh, rl}, {1'b0, CH_OFF, RESULT_RST});
    foreach (cf[i])
    begin
      cfg(cf[i]);
      check(src, cf[i][6] ? 16'h2 : 16'(cf[i][5]));
      repeat (3) conv(5'($urandom_range(30)), 1'($urandom));
      $display("test config %0d done", i);
    end
    cfg(7'h21);
    conv(3, 1);
    hrd = 1; // Software breaks the read order on purpose here
    tick();
    hrd = 0;
    conv(4, 0, 1);
    $display("test torn read done");
    lvl[6] = 11'($urandom);
    repeat (2) expq.push_back({1'b1, rnd(lvl[6])});
    start(6, 1, 1);
    repeat (2) wait_rd();
    cfg(7'h21);
    check(busy, 0);
    start(5, 0, 0);
    tick(10);
    cfg(7'h21);
    check({busy, rh, rl}, {1'b0, rnd(lvl[6])});
    start(5, 0, 0);
    tick(10);
    stp = 1;
    tick(2);
    check(busy, 0);
    stp = 0;
    start(CH_OFF, 0, 0);
    tick();
    check({busy, sel}, {1'b0, CH_OFF});
    cfg(7'h54);
    stp = 1; // Async clock keeps running through stop mode
    conv(7, 0);
    stp = 0;
    start(7, 0, 0);
    tick(5);
    rstn = 0;
    tick();
    rstn = 1;
    tick();
    check({busy, done, rh, rl}, {2'h0, RESULT_RST});
    check(expq.size(), 0);
    $display("test aborts done");
    summarize();
  end
endmodule
`default_nettype wire
